// *** src/agw_defs.svh ***
// constants of the actuator gateway configuration and status block
`ifndef AGW_DEFS_SVH
`define AGW_DEFS_SVH
`define AGW_NODES          8
`define AGW_ADDR_MIN       8'h01
`define AGW_ADDR_MAX       8'hf7
`define AGW_CLK_HZ         200000000
`define AGW_DLY_9600_MS    4
`define AGW_DLY_HI_MS      2
`define AGW_MS_CYC         (`AGW_CLK_HZ / 1000)
`define AGW_DROP_S         10
`define AGW_DROP_MS        (`AGW_DROP_S * 1000)
`define AGW_FLASH_MS       100
`define AGW_ACT_HOLD_MS    8'hff
`define AGW_SETTLE_LAST    2'h3
`define AGW_FC_READ        8'h03
`define AGW_FC_WRITE       8'h06
`define AGW_REG_PER_NODE   20
`define AGW_REG_DELAY      16'h00a3
`define AGW_REG_SETPOINT   5'h00
`define AGW_REG_SENSOR     5'h07
`define AGW_BAUD_9600      2'h0
`endif

// *** src/agw_gateway.sv ***
// actuator gateway configuration, node map and modbus register file
`timescale 1ns/100ps
`include "agw_defs.svh"
module agw_gateway (
    // clock and reset
    input  wire logic               mclk_i,
    input  wire logic               rst_i,
    // dip switches, asynchronous
    input  wire logic [7:0]         addr_sw_i,
    input  wire logic [1:0]         baud_sw_i,
    input  wire logic               parity_sw_i,
    input  wire logic               term_sw_i,
    input  wire logic               bias_sw_i,
    // decoded modbus request from the frame engine
    input  wire logic               req_valid_i,
    input  wire agw_pkg::agw_req_s  req_i,
    // report from the actuator bus engine
    input  wire logic               rpt_valid_i,
    input  wire agw_pkg::agw_rpt_s  rpt_i,
    // modbus answer
    output agw_pkg::agw_cfg_s       cfg_o,
    output logic                    cfg_ready_o,
    output logic                    rsp_valid_o,
    output logic                    rsp_exc_o,
    output logic [15:0]             rsp_data_o,
    output logic [15:0]             rsp_delay_ms_o,
    output logic                    two_stop_o,
    // actuator bus side
    output logic [7:0]              node_present_o,
    output logic                    cmd_valid_o,
    output logic [2:0]              cmd_node_o,
    output logic [4:0]              cmd_reg_o,
    output logic [15:0]             cmd_data_o,
    output logic [7:0]              node_indicator_leds_o
);
    localparam int NREG = `AGW_NODES * `AGW_REG_PER_NODE;

    // switch synchronisers, three stages
    agw_pkg::agw_cfg_s sw_s1, sw_s2, sw_s3;
    agw_pkg::agw_cfg_s sw_raw;
    assign sw_raw = {addr_sw_i, baud_sw_i, parity_sw_i, term_sw_i, bias_sw_i};

    // sync stages only register; first stage read only by the second
    always_ff @(posedge mclk_i) begin
        sw_s1 <= sw_raw;
        sw_s2 <= sw_s1;
        sw_s3 <= sw_s2;
    end

    // configuration capture state
    agw_pkg::agw_cfg_s cfg, next_cfg;
    logic        cfg_ready, next_cfg_ready;
    logic [1:0]  settle, next_settle;       // wait for the pipeline to fill
    logic [7:0]  clamped;

    // clamp the binary switch address into the legal range
    always_comb begin
        clamped = sw_s3.slave_addr;
        if (sw_s3.slave_addr < `AGW_ADDR_MIN) begin
            clamped = `AGW_ADDR_MIN;
        end else if (sw_s3.slave_addr > `AGW_ADDR_MAX) begin
            clamped = `AGW_ADDR_MAX;
        end
    end

    // settings follow switches once the second and third stages agree
    always_comb begin
        next_cfg       = cfg;
        next_cfg_ready = cfg_ready;
        next_settle    = settle;
        if (settle != `AGW_SETTLE_LAST) begin
            next_settle = settle + 2'h1;
        end else if (sw_s2 == sw_s3) begin
            next_cfg.slave_addr  = clamped;
            next_cfg.baud_sel    = sw_s3.baud_sel;
            next_cfg.even_parity = sw_s3.even_parity;
            next_cfg.termination = sw_s3.termination;
            next_cfg.bias        = sw_s3.bias;
            next_cfg_ready       = 1'b1;
        end
    end

    // register the configuration
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            cfg       <= '0;
            cfg_ready <= 1'b0;
            settle    <= 2'h0;
        end else begin
            cfg       <= next_cfg;
            cfg_ready <= next_cfg_ready;
            settle    <= next_settle;
        end
    end

    // timebase: millisecond and blink enables
    logic [17:0] ms_div, next_ms_div;
    logic [6:0]  fl_div, next_fl_div;
    logic        ms_tick, next_ms_tick;
    logic        fl_tick, next_fl_tick;

    // single clock, slower rates as one cycle enables
    always_comb begin
        next_ms_div  = ms_div + 18'h00001;
        next_ms_tick = 1'b0;
        next_fl_div  = fl_div;
        next_fl_tick = 1'b0;
        if (ms_div == 18'(`AGW_MS_CYC - 1)) begin
            next_ms_div  = 18'h00000;
            next_ms_tick = 1'b1;
            next_fl_div  = fl_div + 7'h01;
            if (fl_div == 7'(`AGW_FLASH_MS - 1)) begin
                next_fl_div  = 7'h00;
                next_fl_tick = 1'b1;
            end
        end
    end

    // register the timebase
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            ms_div  <= 18'h00000;
            fl_div  <= 7'h00;
            ms_tick <= 1'b0;
            fl_tick <= 1'b0;
        end else begin
            ms_div  <= next_ms_div;
            fl_div  <= next_fl_div;
            ms_tick <= next_ms_tick;
            fl_tick <= next_fl_tick;
        end
    end

    // per node watchdogs, one instance each
    logic [7:0] present, drop, leds, seen, comm;
    always_comb begin
        seen = '0;
        comm = '0;
        if (rpt_valid_i) begin
            seen[rpt_i.node] = rpt_i.seen;  // three bit index caps at eight
            comm[rpt_i.node] = 1'b1;
        end
    end

    for (genvar n = 0; n < `AGW_NODES; n++) begin : g_node
        agw_node_mon u_mon (
            .mclk_i       (mclk_i),
            .rst_i        (rst_i),
            .ms_tick_i    (ms_tick),
            .flash_tick_i (fl_tick),
            .seen_i       (seen[n]),
            .comm_i       (comm[n]),
            .present_o    (present[n]),
            .drop_o       (drop[n]),
            .led_o        (leds[n])
        );
    end

    // register file, 20 words per node
    logic [15:0] regs [NREG];
    logic [15:0] delay_ms, next_delay_ms;
    logic        rsp_valid, next_rsp_valid;
    logic        rsp_exc, next_rsp_exc;
    logic [15:0] rsp_data, next_rsp_data;
    logic        cmd_valid, next_cmd_valid;
    logic [2:0]  cmd_node, next_cmd_node;
    logic [4:0]  cmd_reg, next_cmd_reg;
    logic [15:0] cmd_data, next_cmd_data;
    logic [15:0] dflt_ms;
    logic        in_map;
    logic [15:0] ridx;

    // default delay depends on baud rate
    always_comb begin
        dflt_ms = (cfg.baud_sel == `AGW_BAUD_9600) ? 16'(`AGW_DLY_9600_MS)
                                                   : 16'(`AGW_DLY_HI_MS);
        ridx    = req_i.reg_addr;
        in_map  = (req_i.reg_addr < 16'(NREG));
    end

    // request handling; answers only after the address is applied
    always_comb begin
        next_delay_ms  = delay_ms;
        next_rsp_valid = 1'b0;
        next_rsp_exc   = 1'b0;
        next_rsp_data  = rsp_data;
        next_cmd_valid = 1'b0;
        next_cmd_node  = cmd_node;
        next_cmd_reg   = cmd_reg;
        next_cmd_data  = cmd_data;
        if (req_valid_i && cfg_ready) begin
            next_rsp_valid = 1'b1;
            if (req_i.func == `AGW_FC_READ) begin
                if (in_map) begin
                    next_rsp_data = regs[ridx[7:0]];
                end else if (req_i.reg_addr == `AGW_REG_DELAY) begin
                    next_rsp_data = delay_ms;
                end else begin
                    next_rsp_exc = 1'b1;
                end
            end else if (req_i.func == `AGW_FC_WRITE) begin
                next_rsp_data = req_i.wdata;
                if (in_map) begin
                    next_cmd_valid = 1'b1;
                    next_cmd_node  = 3'(ridx / 16'(`AGW_REG_PER_NODE));
                    next_cmd_reg   = 5'(ridx % 16'(`AGW_REG_PER_NODE));
                    next_cmd_data  = req_i.wdata;
                end else if (req_i.reg_addr == `AGW_REG_DELAY) begin
                    // only a longer delay than the default takes effect
                    next_delay_ms = req_i.wdata;
                end else begin
                    next_rsp_exc = 1'b1;
                end
            end else begin
                next_rsp_exc = 1'b1;
            end
        end
    end

    // register the answer path and the register file
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            delay_ms  <= 16'h0000;
            rsp_valid <= 1'b0;
            rsp_exc   <= 1'b0;
            rsp_data  <= 16'h0000;
            cmd_valid <= 1'b0;
            cmd_node  <= 3'h0;
            cmd_reg   <= 5'h00;
            cmd_data  <= 16'h0000;
            for (int i = 0; i < NREG; i++) begin
                regs[i] <= 16'h0000;
            end
        end else begin
            delay_ms  <= next_delay_ms;
            rsp_valid <= next_rsp_valid;
            rsp_exc   <= next_rsp_exc;
            rsp_data  <= next_rsp_data;
            cmd_valid <= next_cmd_valid;
            cmd_node  <= next_cmd_node;
            cmd_reg   <= next_cmd_reg;
            cmd_data  <= next_cmd_data;
            for (int n = 0; n < `AGW_NODES; n++) begin
                for (int r = 0; r < `AGW_REG_PER_NODE; r++) begin
                    if (drop[n]) begin
                        regs[n*`AGW_REG_PER_NODE+r] <= 16'h0000;
                    end else if (rpt_valid_i && rpt_i.node == 3'(n)
                                 && rpt_i.reg_idx == 5'(r)) begin
                        regs[n*`AGW_REG_PER_NODE+r] <= rpt_i.value;
                    end else if (next_cmd_valid && next_cmd_node == 3'(n)
                                 && next_cmd_reg == 5'(r)) begin
                        regs[n*`AGW_REG_PER_NODE+r] <= next_cmd_data;
                    end
                end
            end
        end
    end

    // outputs from flip-flops
    logic [15:0] delay_q;
    logic        two_stop_q;
    logic [7:0]  present_q, leds_q;

    // effective delay and framing registered for the outputs
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            delay_q    <= 16'h0000;
            two_stop_q <= 1'b1;
            present_q  <= 8'h00;
            leds_q     <= 8'h00;
        end else begin
            delay_q    <= (delay_ms > dflt_ms) ? delay_ms : dflt_ms;
            two_stop_q <= ~next_cfg.even_parity;  // same edge as cfg_o
            present_q  <= present;
            leds_q     <= leds;
        end
    end

    assign cfg_o                 = cfg;
    assign cfg_ready_o           = cfg_ready;
    assign rsp_valid_o           = rsp_valid;
    assign rsp_exc_o             = rsp_exc;
    assign rsp_data_o            = rsp_data;
    assign rsp_delay_ms_o        = delay_q;
    assign two_stop_o            = two_stop_q;
    assign node_present_o        = present_q;
    assign cmd_valid_o           = cmd_valid;
    assign cmd_node_o            = cmd_node;
    assign cmd_reg_o             = cmd_reg;
    assign cmd_data_o            = cmd_data;
    assign node_indicator_leds_o = leds_q;
endmodule : agw_gateway

// *** src/agw_node_mon.sv ***
// per node presence watchdog and indicator led
`timescale 1ns/100ps
`include "agw_defs.svh"
module agw_node_mon (
    // clock and reset
    input  wire logic mclk_i,
    input  wire logic rst_i,
    // timebase and events
    input  wire logic ms_tick_i,     // one millisecond enable
    input  wire logic flash_tick_i,  // blink phase enable
    input  wire logic seen_i,        // reply from this node
    input  wire logic comm_i,        // traffic with this node
    // status
    output logic      present_o,
    output logic      drop_o,        // pulse when node is discarded
    output logic      led_o
);
    agw_pkg::agw_node_e state, next_state;
    logic [13:0] idle_ms, next_idle_ms;    // ms since last reply
    logic        led, next_led;
    logic [7:0]  act_ms, next_act_ms;      // activity hold time
    logic        drop, next_drop;

    // next state of the watchdog
    always_comb begin
        next_state   = state;
        next_idle_ms = idle_ms;
        next_led     = led;
        next_act_ms  = act_ms;
        next_drop    = 1'b0;
        if (comm_i) begin
            next_act_ms = `AGW_ACT_HOLD_MS; // keep flashing a while after traffic
        end else if (ms_tick_i && act_ms != 8'h00) begin
            next_act_ms = act_ms - 8'h01;
        end
        case (state)
            agw_pkg::AGW_ABSENT: begin
                next_led = 1'b0;
                if (seen_i) begin
                    next_state   = agw_pkg::AGW_PRESENT;
                    next_idle_ms = 14'h0000;
                    next_led     = 1'b1;    // lit as soon as the node answers
                end
            end
            agw_pkg::AGW_PRESENT, agw_pkg::AGW_ACTIVE: begin
                if (seen_i) begin
                    next_idle_ms = 14'h0000;
                end else if (ms_tick_i) begin
                    next_idle_ms = idle_ms + 14'h0001;
                end
                // flash while talking, steady otherwise
                if (act_ms != 8'h00) begin
                    next_state = agw_pkg::AGW_ACTIVE;
                    if (flash_tick_i) begin
                        next_led = ~led;
                    end
                end else begin
                    next_state = agw_pkg::AGW_PRESENT;
                    next_led   = 1'b1;
                end
                if (!seen_i && idle_ms >= 14'(`AGW_DROP_MS)) begin
                    next_state = agw_pkg::AGW_ABSENT;
                    next_led   = 1'b0;
                    next_drop  = 1'b1;
                end
            end
            default: begin
                next_state = agw_pkg::AGW_ABSENT;
            end
        endcase
    end

    // register the watchdog; reset forgets every node
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            state   <= agw_pkg::AGW_ABSENT;
            idle_ms <= 14'h0000;
            led     <= 1'b0;
            act_ms  <= 8'h00;
            drop    <= 1'b0;
        end else begin
            state   <= next_state;
            idle_ms <= next_idle_ms;
            led     <= next_led;
            act_ms  <= next_act_ms;
            drop    <= next_drop;
        end
    end

    assign present_o = (state != agw_pkg::AGW_ABSENT);
    assign drop_o    = drop;
    assign led_o     = led;
endmodule : agw_node_mon

// *** src/agw_pkg.sv ***
// types shared by the actuator gateway configuration and status block
package agw_pkg;
    // slave address and line format from the switches
    typedef struct packed {
        logic [7:0] slave_addr;
        logic [1:0] baud_sel;
        logic       even_parity;
        logic       termination;
        logic       bias;
    } agw_cfg_s;
    // one modbus register request
    typedef struct packed {
        logic [7:0]  func;
        logic [15:0] reg_addr;
        logic [15:0] wdata;
    } agw_req_s;
    // one report from the actuator bus engine
    typedef struct packed {
        logic [2:0]  node;
        logic        seen;
        logic [4:0]  reg_idx;
        logic [15:0] value;
    } agw_rpt_s;
    // node watchdog state
    typedef enum logic [1:0] {AGW_ABSENT, AGW_PRESENT, AGW_ACTIVE} agw_node_e;
endpackage : agw_pkg

// *** testbench/agw_gateway_sva.sv ***
// port level assertions for the gateway configuration and status block
`timescale 1ns/100ps
module agw_gateway_sva (
    // clock and reset
    input  wire logic              mclk_i,
    input  wire logic              rst_i,
    // requests and reports
    input  wire logic              req_valid_i,
    input  wire agw_pkg::agw_req_s req_i,
    input  wire logic              rpt_valid_i,
    input  wire agw_pkg::agw_rpt_s rpt_i,
    // outputs watched
    input  wire agw_pkg::agw_cfg_s cfg_o,
    input  wire logic              cfg_ready_o,
    input  wire logic              rsp_valid_o,
    input  wire logic              rsp_exc_o,
    input  wire logic [15:0]       rsp_delay_ms_o,
    input  wire logic              two_stop_o,
    input  wire logic [7:0]        node_present_o,
    input  wire logic              cmd_valid_o,
    input  wire logic [15:0]       cmd_data_o,
    input  wire logic [7:0]        node_indicator_leds_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    // request taken only once switches are applied
    sequence s_take;
        req_valid_i && cfg_ready_o;
    endsequence
    // legal write into the actuator blocks
    sequence s_write;
        s_take ##0 (req_i.func == 8'h06 && req_i.reg_addr < 16'h00a0);
    endsequence
    // command forwarded with a clean answer
    sequence s_cmd;
        cmd_valid_o && rsp_valid_o && !rsp_exc_o;
    endsequence
    AST_RSP_LAT: assert property (s_take |=> rsp_valid_o)
        else $error("no answer one cycle after request");
    AST_NO_EARLY: assert property (rsp_valid_o |-> $past(req_valid_i && cfg_ready_o))
        else $error("answer without a taken request");
    AST_BAD_FUNC: assert property (s_take ##0
        (req_i.func != 8'h03 && req_i.func != 8'h06) |=> rsp_exc_o)
        else $error("unsupported function not refused");
    AST_BAD_ADDR: assert property (s_take ##0 (req_i.reg_addr > 16'h009f
        && req_i.reg_addr != 16'h00a3) |=> rsp_exc_o) else $error("bad address not refused");
    AST_WRITE_CMD: assert property (s_write |=> s_cmd ##0
        (cmd_data_o == $past(req_i.wdata))) else $error("write not forwarded to actuator");
    AST_ADDR_RANGE: assert property (cfg_ready_o |->
        cfg_o.slave_addr inside {[8'h01:8'hf7]}) else $error("slave address out of range");
    AST_TWO_STOP: assert property (cfg_ready_o |-> two_stop_o == !cfg_o.even_parity)
        else $error("stop bits do not follow parity");
    AST_DELAY_MIN: assert property (cfg_ready_o |-> rsp_delay_ms_o >=
        ((cfg_o.baud_sel == 2'h0) ? 16'h0004 : 16'h0002)) else $error("delay below default");
    AST_PRESENT: assert property (rpt_valid_i && rpt_i.seen |->
        ##2 node_present_o[$past(rpt_i.node, 2)]) else $error("seen node not marked present");
    AST_LED_ABSENT: assert property ((node_indicator_leds_o & ~node_present_o) == 8'h00)
        else $error("led lit for absent node");
endmodule : agw_gateway_sva

bind agw_gateway agw_gateway_sva agw_gateway_sva_i (.mclk_i, .rst_i, .req_valid_i, .req_i,
    .rpt_valid_i, .rpt_i, .cfg_o, .cfg_ready_o, .rsp_valid_o, .rsp_exc_o, .rsp_delay_ms_o,
    .two_stop_o, .node_present_o, .cmd_valid_o, .cmd_data_o, .node_indicator_leds_o);

// *** testbench/agw_gateway_tb.sv ***
// self-checking bench for the gateway configuration and status block
`timescale 1ns/100ps
module agw_gateway_tb;
    logic              mclk, rst, req_valid, rpt_valid, parity_sw, term_sw, bias_sw;
    logic [7:0]        addr_sw;
    logic [1:0]        baud_sw;
    agw_pkg::agw_req_s req;
    agw_pkg::agw_rpt_s rpt;
    agw_pkg::agw_cfg_s cfg;
    logic              cfg_ready, rsp_valid, rsp_exc, two_stop, cmd_valid;
    logic [15:0]       rsp_data, rsp_delay, cmd_data;
    logic [7:0]        present, leds;
    logic [2:0]        cmd_node;
    logic [4:0]        cmd_reg;
    int                mismatches, comparisons, cycles;
    agw_gateway agw_gateway_i (.mclk_i(mclk), .rst_i(rst), .addr_sw_i(addr_sw),
        .baud_sw_i(baud_sw), .parity_sw_i(parity_sw), .term_sw_i(term_sw), .bias_sw_i(bias_sw),
        .req_valid_i(req_valid), .req_i(req), .rpt_valid_i(rpt_valid), .rpt_i(rpt),
        .cfg_o(cfg), .cfg_ready_o(cfg_ready), .rsp_valid_o(rsp_valid), .rsp_exc_o(rsp_exc),
        .rsp_data_o(rsp_data), .rsp_delay_ms_o(rsp_delay), .two_stop_o(two_stop),
        .node_present_o(present), .cmd_valid_o(cmd_valid), .cmd_node_o(cmd_node),
        .cmd_reg_o(cmd_reg), .cmd_data_o(cmd_data), .node_indicator_leds_o(leds));
    agw_mb_master agw_mb_master_i (.mclk_i(mclk), .rsp_valid_i(rsp_valid),
        .rsp_exc_i(rsp_exc), .rsp_data_i(rsp_data), .req_valid_o(req_valid), .req_o(req));
    // free running 200 MHz clock
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // hang guard, far above the few hundred cycles the tests need
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            stop_test();
        end
    end
    // one compare, counted and reported
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // reset with given switches; an early request must stay unanswered
    task automatic do_reset(input logic [7:0] a, input logic [1:0] b, input logic p);
        int n;
        @(posedge mclk);
        #1;
        {addr_sw, baud_sw, parity_sw, term_sw, bias_sw, rst} = {a, b, p, p, ~p, 1'b1};
        repeat (20) @(posedge mclk);
        #1;
        rst = 1'b0;
        agw_mb_master_i.issue(8'h03, 16'h0000, 16'h0000);
        chk({15'h0, agw_mb_master_i.got_valid}, 16'h0000);
        n = 0;
        while (cfg_ready !== 1'b1 && n < 50) begin
            @(posedge mclk);
            #1;
            n++;
        end
        // delay output follows the applied settings one edge later
        @(posedge mclk);
        #1;
        chk({15'h0, cfg_ready}, 16'h0001);
        chk({8'h0, present}, 16'h0000);
    endtask : do_reset
    // switch table: address clamp, line format, default delay
    task automatic t_cfg();
        logic [7:0] sw [6] = '{8'h00, 8'h01, 8'h7f, 8'hf7, 8'hf8, 8'hff};
        logic [7:0] ex [6] = '{8'h01, 8'h01, 8'h7f, 8'hf7, 8'hf7, 8'hf7};
        for (int i = 0; i < 6; i++) begin
            do_reset(sw[i], i[1:0], i[0]);
            chk({8'h0, cfg.slave_addr}, {8'h0, ex[i]});
            chk({14'h0, cfg.baud_sel}, {14'h0, i[1:0]});
            chk({13'h0, cfg.even_parity, cfg.termination, cfg.bias},
                {13'h0, i[0], i[0], ~i[0]});
            chk({15'h0, two_stop}, {15'h0, ~i[0]});
            chk(rsp_delay, (i[1:0] == 2'h0) ? 16'h0004 : 16'h0002);
        end
        $display("test cfg done");
    endtask : t_cfg
    // write forwarded to the actuator and read back, incl. last register
    task automatic t_rw();
        logic [15:0] ad [2] = '{16'h0015, 16'h009f};
        logic [15:0] dt [2] = '{16'hbeef, 16'h5a5a};
        for (int i = 0; i < 2; i++) begin
            agw_mb_master_i.issue(8'h06, ad[i], dt[i]);
            chk({agw_mb_master_i.got_valid, agw_mb_master_i.got_exc, 14'h0}, 16'h8000);
            chk(agw_mb_master_i.got_data, dt[i]);
            chk({cmd_valid, 7'h0, cmd_node, cmd_reg},
                {1'b1, 7'h0, 3'(ad[i] / 16'h0014), 5'(ad[i] % 16'h0014)});
            chk(cmd_data, dt[i]);
            agw_mb_master_i.issue(8'h03, ad[i], 16'h0000);
            chk(agw_mb_master_i.got_data, dt[i]);
        end
        $display("test rw done");
    endtask : t_rw
    // unsupported functions and unmapped addresses are refused
    task automatic t_exc();
        logic [7:0]  fn [5] = '{8'h04, 8'h10, 8'h00, 8'h03, 8'h06};
        logic [15:0] ad [5] = '{16'h0000, 16'h0000, 16'h0000, 16'h00a0, 16'h00a4};
        for (int i = 0; i < 5; i++) begin
            agw_mb_master_i.issue(fn[i], ad[i], 16'h0001);
            chk({agw_mb_master_i.got_valid, agw_mb_master_i.got_exc, 14'h0}, 16'hc000);
        end
        $display("test exc done");
    endtask : t_exc
    // written delay only lengthens the default
    task automatic t_delay();
        logic [15:0] wr [3] = '{16'h000a, 16'h0001, 16'h0000};
        logic [15:0] ex [3] = '{16'h000a, 16'h0004, 16'h0004};
        for (int i = 0; i < 3; i++) begin
            agw_mb_master_i.issue(8'h06, 16'h00a3, wr[i]);
            repeat (2) @(posedge mclk);
            #1;
            chk(rsp_delay, ex[i]);
        end
        $display("test delay done");
    endtask : t_delay
    // one report; checked in the second cycle after it is taken
    task automatic report(input logic [2:0] n, input logic [15:0] v);
        @(posedge mclk);
        #1;
        rpt_valid = 1'b1;
        rpt       = '{n, 1'b1, 5'h07, v};
        @(posedge mclk);
        #1;
        rpt_valid = 1'b0;
        rpt       = ~rpt;
        @(posedge mclk);
        #1;
    endtask : report
    // node detection, leds and sensor readout, up to the eighth node
    task automatic t_rpt();
        report(3'h2, 16'h1234);
        chk({8'h0, present}, 16'h0004);
        chk({8'h0, leds}, 16'h0004);
        agw_mb_master_i.issue(8'h03, 16'h002f, 16'h0000);
        chk(agw_mb_master_i.got_data, 16'h1234);
        report(3'h7, 16'h4321);
        chk({8'h0, present}, 16'h0084);
        chk({8'h0, leds}, 16'h0084);
        agw_mb_master_i.issue(8'h03, 16'h0093, 16'h0000);
        chk(agw_mb_master_i.got_data, 16'h4321);
        $display("test rpt done");
    endtask : t_rpt
    // counts, verdict and end of run
    task automatic stop_test();
        $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test
    // main sequence
    initial begin
        {rst, rpt_valid, addr_sw, baud_sw, parity_sw, term_sw, bias_sw} = {2'b10, 13'h0};
        rpt = '0;
        t_cfg();
        do_reset(8'h10, 2'h0, 1'b0);
        t_rw();
        t_exc();
        t_delay();
        t_rpt();
        do_reset(8'h10, 2'h0, 1'b0);
        stop_test();
    end
endmodule : agw_gateway_tb

// *** testbench/agw_mb_master.sv ***
// modbus master stand-in that hands decoded requests to the gateway
`timescale 1ns/100ps
module agw_mb_master (
    // clock
    input  wire logic              mclk_i,
    // answer from the gateway
    input  wire logic              rsp_valid_i,
    input  wire logic              rsp_exc_i,
    input  wire logic [15:0]       rsp_data_i,
    // request toward the gateway
    output logic                   req_valid_o,
    output agw_pkg::agw_req_s      req_o
);
    logic        got_valid;  // answer flag seen in the answer cycle
    logic        got_exc;    // refusal flag seen with it
    logic [15:0] got_data;   // word carried by the answer
    initial begin
        req_valid_o = 1'b0;
        req_o       = '0;
    end
    // one request held across exactly one taking edge; answer sampled one cycle later
    task automatic issue(input logic [7:0] func, input logic [15:0] addr,
                         input logic [15:0] data);
        @(posedge mclk_i);
        #1;
        req_valid_o = 1'b1;
        req_o       = '{func, addr, data};
        @(posedge mclk_i);
        #1;
        req_valid_o = 1'b0;
        // released lines carry no stale copy of the request
        req_o       = ~req_o;
        got_valid   = rsp_valid_i;
        got_exc     = rsp_exc_i;
        got_data    = rsp_data_i;
    endtask : issue
endmodule : agw_mb_master
